// >>> ebpwm_regs.svh
// Register offsets, field codes, reset values and timing counts of the PWM unit
`ifndef EBPWM_REGS_SVH
`define EBPWM_REGS_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define EBPWM_OFF_CTRL    8'h00
`define EBPWM_OFF_DUTYLO  8'h04
`define EBPWM_OFF_DUTYWK  8'h08
`define EBPWM_OFF_PERLIM  8'h0C
`define EBPWM_OFF_PERTMR  8'h10
`define EBPWM_OFF_TCTL    8'h14
`define EBPWM_OFF_DBAND   8'h18
`define EBPWM_OFF_CAPCTL  8'h1C
`define EBPWM_OFF_CAPA    8'h20
`define EBPWM_OFF_CAPB    8'h24
`define EBPWM_OFF_STAT    8'h28

// -----------------------------------------------------------------
// Field codes and reset values
// -----------------------------------------------------------------
`define EBPWM_CFG_SINGLE  2'h0
`define EBPWM_CFG_FWD     2'h1
`define EBPWM_CFG_HALF    2'h2
`define EBPWM_CFG_REV     2'h3
`define EBPWM_MODE_OFF    4'h0
`define EBPWM_MODE_SPEVT  4'hB
`define EBPWM_MODE_PWMHI  2'h3
`define EBPWM_PRE_1       2'h0
`define EBPWM_PRE_4       2'h1
`define EBPWM_DIV_1       4'h0
`define EBPWM_DIV_4       4'h3
`define EBPWM_DIV_16      4'hF
`define EBPWM_CLAIM_ONE   4'h1
`define EBPWM_CLAIM_TWO   4'h3
`define EBPWM_CLAIM_ALL   4'hF
`define EBPWM_RST_BYTE    8'h00
`define EBPWM_RST_WORD    16'h0000

// -----------------------------------------------------------------
// Timing: oscillator period and instruction cycle
// -----------------------------------------------------------------
`define EBPWM_CLK_NS      10
`define EBPWM_TCY_NS      40
`define EBPWM_TCY_CLKS    (`EBPWM_TCY_NS / `EBPWM_CLK_NS)
`define EBPWM_TCY_LAST    2'(`EBPWM_TCY_CLKS - 1)

`endif

// >>> ebpwm_pkg.sv
// Types shared by the enhanced bridge PWM unit
package ebpwm_pkg;

   // Bus data-phase tracking
   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} ebpwm_bus_t;

   // PWM run state
   typedef enum logic [1:0] {UNIT_OFF, UNIT_ARMED, UNIT_RUN} ebpwm_unit_t;

   // Unit control register layout
   typedef struct packed {
      logic [1:0] outCfg;
      logic [1:0] dutyLsb;
      logic [3:0] mode;
   } ebpwm_ctrl_t;

   // Period timer control register layout
   typedef struct packed {
      logic [3:0] postscale;
      logic       on;
      logic [1:0] prescale;
   } ebpwm_tctl_t;

endpackage

// >>> ebpwm_top.sv
// Enhanced bridge PWM unit with AHB-Lite register slave
//
// Behaviour
// - Special-event compare clears the selected 16-bit capture timer.
// - Capture timers serve compare; the 8-bit period timer serves PWM.
// - Duty, config and polarity shadows load only at the period boundary.
// - Dead-band working copy loads at duty or period boundary.
// - Once enabled, PWM waits for the period timer to wrap.
// - Period is (limit+1) x 4 clocks x prescale of 1, 4 or 16.
// - At limit match: clear timer, set output unless 0%, load duty.
// - Postscaler divides only an update event, never the PWM rate.
// - Duty is 10 bits: low register high bits, control bits 5:4.
// - High time is duty x one clock x prescale.
// - Duty writes anytime; working copy loads at match, read-only in PWM mode.
// - Output clears when working duty equals timer with phase bits.
// - Duty beyond the period never clears the output.
// - Config 00 single, 10 half, 01 full forward, 11 full reverse.
// - Pins claimed: single A, half A and B, full all four.
// - Half-bridge drives PWM on A and its complement on B.
// - Half-bridge inactive-to-active edges delayed by count instruction cycles.
// - Delay longer than active span keeps that output inactive.
// - Forward: A on, D modulated; reverse: C on, B modulated.
// - Software picks active-high or active-low through mode bits.
// - Mode bit 1 sets A/C polarity, bit 0 sets B/D polarity.
// - Mode code 0000 turns the unit off and resets it.
`timescale 1ns/100ps
`include "ebpwm_regs.svh"

module ebpwm_top
   import ebpwm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Bridge outputs and their drive enables
   output logic             bridgeOutA,
   output logic             bridgeOutB,
   output logic             bridgeOutC,
   output logic             bridgeOutD,
   output logic             bridgeOeA,
   output logic             bridgeOeB,
   output logic             bridgeOeC,
   output logic             bridgeOeD,
   // Postscaled period-match event
   output logic             updatePulse
);

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   ebpwm_bus_t  busSt;
   ebpwm_bus_t  next_busSt;
   logic [7:0]  addrQ;
   logic [7:0]  next_addrQ;
   logic [31:0] next_hrdata;
   logic        next_hreadyout;
   logic        wrEn;
   logic [31:0] rdMux;

   // Registers and core state
   ebpwm_ctrl_t ctrl;
   ebpwm_ctrl_t next_ctrl;
   ebpwm_tctl_t tctl;
   ebpwm_tctl_t next_tctl;
   ebpwm_unit_t unitSt;
   ebpwm_unit_t next_unitSt;
   logic [7:0]  dutyLow;
   logic [7:0]  next_dutyLow;
   logic [7:0]  dutyWorkHi;
   logic [7:0]  next_dutyWorkHi;
   logic [1:0]  dutyLatch;
   logic [1:0]  next_dutyLatch;
   logic [7:0]  perLim;
   logic [7:0]  next_perLim;
   logic [7:0]  perTmr;
   logic [7:0]  next_perTmr;
   logic [6:0]  dbCount;
   logic [6:0]  next_dbCount;
   logic [6:0]  dbWork;
   logic [6:0]  next_dbWork;
   logic [1:0]  capCtl;
   logic [1:0]  next_capCtl;
   logic [15:0] capA;
   logic [15:0] next_capA;
   logic [15:0] capB;
   logic [15:0] next_capB;
   logic [1:0]  shCfg;
   logic [1:0]  next_shCfg;
   logic [1:0]  shPol;
   logic [1:0]  next_shPol;
   logic [3:0]  divCnt;
   logic [3:0]  next_divCnt;
   logic [1:0]  subCnt;
   logic [1:0]  next_subCnt;
   logic [1:0]  qCnt;
   logic [1:0]  next_qCnt;
   logic        pwmRaw;
   logic        next_pwmRaw;
   logic [8:0]  dlyA;
   logic [8:0]  next_dlyA;
   logic [8:0]  dlyB;
   logic [8:0]  next_dlyB;
   logic [3:0]  postCnt;
   logic [3:0]  next_postCnt;

   // Derived terms and output next values
   logic        isPwm;
   logic        run;
   logic [3:0]  divLast;
   logic        stepEn;
   logic        subWrap;
   logic        boundary;
   logic        dutyHit;
   logic        tcyTick;
   logic [9:0]  newDuty;
   logic [15:0] cmpVal;
   logic [1:0]  cfgUse;
   logic [1:0]  polUse;
   logic [3:0]  act;
   logic [3:0]  claim;
   logic [3:0]  next_out;
   logic [3:0]  next_oe;
   logic        next_update;

   // Register read multiplexer
   always_comb begin
      unique case (addrQ)
         `EBPWM_OFF_CTRL:   rdMux = {24'h000000, ctrl};
         `EBPWM_OFF_DUTYLO: rdMux = {24'h000000, dutyLow};
         `EBPWM_OFF_DUTYWK: rdMux = {24'h000000, dutyWorkHi};
         `EBPWM_OFF_PERLIM: rdMux = {24'h000000, perLim};
         `EBPWM_OFF_PERTMR: rdMux = {24'h000000, perTmr};
         `EBPWM_OFF_TCTL:   rdMux = {25'h0000000, tctl};
         `EBPWM_OFF_DBAND:  rdMux = {25'h0000000, dbCount};
         `EBPWM_OFF_CAPCTL: rdMux = {30'h00000000, capCtl};
         `EBPWM_OFF_CAPA:   rdMux = {16'h0000, capA};
         `EBPWM_OFF_CAPB:   rdMux = {16'h0000, capB};
         `EBPWM_OFF_STAT:   rdMux = {29'h00000000, pwmRaw,
                                     unitSt == UNIT_ARMED,
                                     unitSt == UNIT_RUN};
         default:           rdMux = 32'h00000000;
      endcase
   end

   // Bus phase tracking; reads take one wait state
   always_comb begin
      next_busSt     = BUS_IDLE;
      next_addrQ     = addrQ;
      next_hrdata    = hrdata;
      next_hreadyout = 1'b1;
      if (busSt == BUS_READ) begin
         next_hrdata = rdMux;
      end else if (hready && hsel && htrans[1]) begin
         next_addrQ = haddr[7:0];
         if (hwrite) begin
            next_busSt = BUS_WRITE;
         end else begin
            next_busSt     = BUS_READ;
            next_hreadyout = 1'b0;
         end
      end
   end

   assign wrEn = (busSt == BUS_WRITE);

   // Bus registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busSt     <= BUS_IDLE;
         addrQ     <= `EBPWM_RST_BYTE;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         busSt     <= next_busSt;
         addrQ     <= next_addrQ;
         hrdata    <= next_hrdata;
         hreadyout <= next_hreadyout;
         hresp     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Time base and PWM core
   // ----------------------------------------------------------------
   assign isPwm   = (ctrl.mode[3:2] == `EBPWM_MODE_PWMHI);
   assign run     = (unitSt == UNIT_RUN);
   assign divLast = (tctl.prescale == `EBPWM_PRE_1) ? `EBPWM_DIV_1 :
                    (tctl.prescale == `EBPWM_PRE_4) ? `EBPWM_DIV_4 :
                    `EBPWM_DIV_16;
   assign stepEn   = tctl.on && (divCnt == divLast);
   assign subWrap  = stepEn && (subCnt == 2'h3);
   assign boundary = subWrap && (perTmr == perLim);
   // Clear as the count steps onto the duty; beyond the period never
   assign dutyHit  = run && stepEn &&
                     ({1'b0, perTmr, subCnt} + 11'h001 ==
                      {1'b0, dutyWorkHi, dutyLatch});
   assign tcyTick  = (qCnt == `EBPWM_TCY_LAST);
   assign newDuty  = {dutyLow, ctrl.dutyLsb};
   assign cmpVal   = {dutyWorkHi, dutyLow};

   // Next values of registers, timers and PWM state
   always_comb begin
      next_ctrl       = ctrl;
      next_tctl       = tctl;
      next_unitSt     = unitSt;
      next_dutyLow    = dutyLow;
      next_dutyWorkHi = dutyWorkHi;
      next_dutyLatch  = dutyLatch;
      next_perLim     = perLim;
      next_perTmr     = perTmr;
      next_dbCount    = dbCount;
      next_dbWork     = dbWork;
      next_capCtl     = capCtl;
      next_capA       = capA;
      next_capB       = capB;
      next_shCfg      = shCfg;
      next_shPol      = shPol;
      next_pwmRaw     = pwmRaw;
      next_postCnt    = postCnt;
      next_qCnt       = qCnt + 2'h1;
      next_divCnt     = stepEn ? 4'h0 : divCnt + 4'h1;
      next_subCnt     = stepEn ? subCnt + 2'h1 : subCnt;
      next_update     = 1'b0;
      if (!tctl.on) begin
         next_divCnt = 4'h0;
      end
      // Period timer; postscaler only paces the update event
      if (subWrap) begin
         next_perTmr = boundary ? 8'h00 : perTmr + 8'h01;
      end
      if (boundary) begin
         next_postCnt = postCnt + 4'h1;
         if (postCnt == tctl.postscale) begin
            next_postCnt = 4'h0;
            next_update  = 1'b1;
         end
      end
      // Capture timers count instruction cycles
      if (capCtl[1] && tcyTick) begin
         next_capA = capA + 16'h0001;
         next_capB = capB + 16'h0001;
      end
      // Special event makes the compare value a 16-bit period
      if (ctrl.mode == `EBPWM_MODE_SPEVT) begin
         if (!capCtl[0] && capA == cmpVal) begin
            next_capA = `EBPWM_RST_WORD;
         end
         if (capCtl[0] && capB == cmpVal) begin
            next_capB = `EBPWM_RST_WORD;
         end
      end
      // Run state and shadow loads
      unique case (unitSt)
         UNIT_OFF: begin
            if (isPwm) begin
               next_unitSt = UNIT_ARMED;
            end
         end
         UNIT_ARMED: begin
            if (!isPwm) begin
               next_unitSt = UNIT_OFF;
            end else if (boundary) begin
               next_unitSt = UNIT_RUN;
            end
         end
         UNIT_RUN: begin
            if (!isPwm) begin
               next_unitSt = UNIT_OFF;
               next_pwmRaw = 1'b0;
            end
         end
      endcase
      if (isPwm && boundary) begin
         next_dutyWorkHi = newDuty[9:2];
         next_dutyLatch  = newDuty[1:0];
         next_shCfg      = ctrl.outCfg;
         next_shPol      = ctrl.mode[1:0];
         next_dbWork     = dbCount;
         next_pwmRaw     = (newDuty != 10'h000);
      end else if (dutyHit) begin
         next_pwmRaw  = 1'b0;
         next_dbWork  = dbCount;
      end
      // Dead-band counters in clocks, four per instruction cycle;
      // counting clocks keeps the gap from shrinking with the phase
      next_dlyA = dlyA;
      next_dlyB = dlyB;
      if (!pwmRaw) begin
         next_dlyA = 9'h000;
      end else if (dlyA < {dbWork, 2'b00}) begin
         next_dlyA = dlyA + 9'h001;
      end
      if (pwmRaw || !run) begin
         next_dlyB = 9'h000;
      end else if (dlyB < {dbWork, 2'b00}) begin
         next_dlyB = dlyB + 9'h001;
      end
      // Software writes win over hardware updates, save the off-code clear of dutyWorkHi
      if (wrEn) begin
         unique case (addrQ)
            `EBPWM_OFF_CTRL:   next_ctrl    = hwdata[7:0];
            `EBPWM_OFF_DUTYLO: next_dutyLow = hwdata[7:0];
            `EBPWM_OFF_DUTYWK: begin
               if (!isPwm) begin
                  next_dutyWorkHi = hwdata[7:0];
               end
            end
            `EBPWM_OFF_PERLIM: next_perLim  = hwdata[7:0];
            `EBPWM_OFF_PERTMR: next_perTmr  = hwdata[7:0];
            `EBPWM_OFF_TCTL:   next_tctl    = hwdata[6:0];
            `EBPWM_OFF_DBAND:  next_dbCount = hwdata[6:0];
            `EBPWM_OFF_CAPCTL: next_capCtl  = hwdata[1:0];
            `EBPWM_OFF_CAPA:   next_capA    = hwdata[15:0];
            `EBPWM_OFF_CAPB:   next_capB    = hwdata[15:0];
            default: ;
         endcase
      end
      // Off code returns the unit to its reset state
      if (ctrl.mode == `EBPWM_MODE_OFF) begin
         next_unitSt     = UNIT_OFF;
         next_pwmRaw     = 1'b0;
         next_dutyWorkHi = `EBPWM_RST_BYTE;
         next_dutyLatch  = 2'h0;
         next_dbWork     = 7'h00;
         next_shCfg      = `EBPWM_CFG_SINGLE;
         next_shPol      = 2'h0;
         next_dlyA       = 9'h000;
         next_dlyB       = 9'h000;
      end
   end

   // Core registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrl       <= `EBPWM_RST_BYTE;
         tctl       <= 7'h00;
         unitSt     <= UNIT_OFF;
         dutyLow    <= `EBPWM_RST_BYTE;
         dutyWorkHi <= `EBPWM_RST_BYTE;
         dutyLatch  <= 2'h0;
         perLim     <= `EBPWM_RST_BYTE;
         perTmr     <= `EBPWM_RST_BYTE;
         dbCount    <= 7'h00;
         dbWork     <= 7'h00;
         capCtl     <= 2'h0;
         capA       <= `EBPWM_RST_WORD;
         capB       <= `EBPWM_RST_WORD;
         shCfg      <= `EBPWM_CFG_SINGLE;
         shPol      <= 2'h0;
         divCnt     <= 4'h0;
         subCnt     <= 2'h0;
         qCnt       <= 2'h0;
         pwmRaw     <= 1'b0;
         dlyA       <= 9'h000;
         dlyB       <= 9'h000;
         postCnt    <= 4'h0;
      end else begin
         ctrl       <= next_ctrl;
         tctl       <= next_tctl;
         unitSt     <= next_unitSt;
         dutyLow    <= next_dutyLow;
         dutyWorkHi <= next_dutyWorkHi;
         dutyLatch  <= next_dutyLatch;
         perLim     <= next_perLim;
         perTmr     <= next_perTmr;
         dbCount    <= next_dbCount;
         dbWork     <= next_dbWork;
         capCtl     <= next_capCtl;
         capA       <= next_capA;
         capB       <= next_capB;
         shCfg      <= next_shCfg;
         shPol      <= next_shPol;
         divCnt     <= next_divCnt;
         subCnt     <= next_subCnt;
         qCnt       <= next_qCnt;
         pwmRaw     <= next_pwmRaw;
         dlyA       <= next_dlyA;
         dlyB       <= next_dlyB;
         postCnt    <= next_postCnt;
      end
   end

   // ----------------------------------------------------------------
   // Output steering
   // ----------------------------------------------------------------
   assign cfgUse = run ? shCfg : ctrl.outCfg;
   assign polUse = run ? shPol : ctrl.mode[1:0];

   // Active levels per configuration, then pin claims and polarity
   always_comb begin
      act = 4'h0;
      if (run) begin
         unique case (shCfg)
            `EBPWM_CFG_SINGLE: act = {3'h0, pwmRaw};
            `EBPWM_CFG_HALF: begin
               act[0] = pwmRaw && dlyA >= {dbWork, 2'b00};
               act[1] = !pwmRaw && dlyB >= {dbWork, 2'b00};
            end
            `EBPWM_CFG_FWD: act = {pwmRaw, 2'h0, 1'b1};
            `EBPWM_CFG_REV: act = {1'b0, 1'b1, pwmRaw, 1'b0};
         endcase
      end
      unique case (cfgUse)
         `EBPWM_CFG_SINGLE: claim = `EBPWM_CLAIM_ONE;
         `EBPWM_CFG_HALF:   claim = `EBPWM_CLAIM_TWO;
         `EBPWM_CFG_FWD,
         `EBPWM_CFG_REV:    claim = `EBPWM_CLAIM_ALL;
      endcase
      next_oe = (isPwm && unitSt != UNIT_OFF) ? claim : 4'h0;
      // Inversion after dead band; idle pins are held low whatever the polarity
      next_out = next_oe & (act ^ {polUse[0], polUse[1],
                                   polUse[0], polUse[1]});
   end

   // Output flip-flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {bridgeOutD, bridgeOutC, bridgeOutB, bridgeOutA} <= 4'h0;
         {bridgeOeD, bridgeOeC, bridgeOeB, bridgeOeA}     <= 4'h0;
         updatePulse <= 1'b0;
      end else begin
         {bridgeOutD, bridgeOutC, bridgeOutB, bridgeOutA} <= next_out;
         {bridgeOeD, bridgeOeC, bridgeOeB, bridgeOeA}     <= next_oe;
         updatePulse <= next_update;
      end
   end

endmodule

// >>> ebpwm_chk.sv
// Port-level assertions for the enhanced bridge PWM unit
`timescale 1ns/100ps

module ebpwm_chk
   import ebpwm_pkg::*;
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       reset_n,
   // Register bus
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   // Bridge pins and update event
   input wire logic       bridgeOutA,
   input wire logic       bridgeOutB,
   input wire logic       bridgeOutC,
   input wire logic       bridgeOutD,
   input wire logic       bridgeOeA,
   input wire logic       bridgeOeB,
   input wire logic       bridgeOeC,
   input wire logic       bridgeOeD,
   input wire logic       updatePulse
);
   // ----------------------------------------------------------
   // Common clock and reset
   // ----------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // Bus answers
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("response not OKAY");
   property p_rdwait;
      hsel && hready && htrans[1] && !hwrite |=> !hreadyout;
   endproperty
   a_rdwait: assert property (p_rdwait) else $error("read has no wait");
   property p_wrfast;
      hsel && hready && htrans[1] && hwrite |=> hreadyout;
   endproperty
   a_wrfast: assert property (p_wrfast) else $error("write stalled");
   property p_onewait; !hreadyout |=> hreadyout; endproperty
   a_onewait: assert property (p_onewait) else $error("wait too long");

   // Update spacing, pin claims and levels
   property p_spacing; updatePulse |=> !updatePulse [*3]; endproperty
   a_spacing: assert property (p_spacing) else $error("period short");
   property p_claimb; bridgeOeB |-> bridgeOeA; endproperty
   a_claimb: assert property (p_claimb) else $error("B without A");
   property p_claimall;
      bridgeOeC || bridgeOeD |-> bridgeOeA && bridgeOeB && bridgeOeC
         && bridgeOeD;
   endproperty
   a_claimall: assert property (p_claimall) else $error("partial");
   property p_idle;
      (!bridgeOeA -> !bridgeOutA) && (!bridgeOeB -> !bridgeOutB)
         && (!bridgeOeC -> !bridgeOutC) && (!bridgeOeD -> !bridgeOutD);
   endproperty
   a_idle: assert property (p_idle) else $error("unclaimed pin high");
endmodule

// >>> ebpwm_switch.sv
// Power switch driver model watching the bridge pins
`timescale 1ns/100ps

module ebpwm_switch
   import ebpwm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Bridge pins and drive enables
   input  wire logic [3:0]  pinOut,
   input  wire logic [3:0]  pinOe,
   // Cycles with both switches of the A/B leg on
   output logic      [15:0] shootCnt
);
   logic [3:0] line;

   // Undriven pins sit at the pull-down level
   assign line = pinOut & pinOe;

   // Count shoot-through cycles on the A/B leg
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         shootCnt <= 16'h0000;
      end else if (line[0] && line[1]) begin
         shootCnt <= shootCnt + 16'h0001;
      end
   end
endmodule

// >>> ebpwm_tb.sv
// Self-checking bench for the enhanced bridge PWM unit
`timescale 1ns/100ps
`include "ebpwm_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %0t got %0h expected %0h", $time, (g), (e)); end end

module tb
   import ebpwm_pkg::*;
;
   // Table row: settings and high cycles per period of A..D
   typedef struct {
      logic [7:0] ctl, lo, tc;
      logic [3:0] oe;
      logic [7:0] a, b, c, d;
   } ebpwm_row_t;

   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hrdata, v;
   logic        hready, hreadyout, hresp, updatePulse;
   logic [3:0]  pout, poe;
   logic [15:0] shootCnt, s0, lim;
   logic [15:0] cnt [6];
   int          n_fail = 0;
   int          n_checks = 0;
   int          per;
   ebpwm_row_t  r;
   ebpwm_row_t  rows [10];

   // 100 MHz clock; single slave so hready follows hreadyout
   always #5 clk_sys = ~clk_sys;
   assign hready = hreadyout;

   ebpwm_top i_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .bridgeOutA(pout[0]), .bridgeOutB(pout[1]),
      .bridgeOutC(pout[2]), .bridgeOutD(pout[3]), .bridgeOeA(poe[0]),
      .bridgeOeB(poe[1]), .bridgeOeC(poe[2]), .bridgeOeD(poe[3]),
      .updatePulse(updatePulse));

   ebpwm_switch i_sw (.clk_sys(clk_sys), .reset_n(reset_n), .pinOut(pout),
      .pinOe(poe), .shootCnt(shootCnt));

   // ----------------------------------------------------------
   // Bus and measuring tasks
   // ----------------------------------------------------------
   // One single transfer; read data taken with the closing hready
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge clk_sys);
      htrans <= 2'h2;
      hsel <= 1'b1;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge clk_sys); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hready !== 1'b1);
      v = hrdata;
   endtask

   // High cycles of each pin, rises of A and update pulses
   task automatic meas(input int n);
      logic pa;
      pa = pout[0];
      foreach (cnt[i]) cnt[i] = 16'h0000;
      repeat (n) begin
         @(posedge clk_sys);
         for (int i = 0; i < 4; i++) cnt[i] += pout[i];
         cnt[4] += (pout[0] && !pa);
         cnt[5] += updatePulse;
         pa = pout[0];
      end
   endtask

   // Count summary, verdict and end of run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      give_verdict();
   end

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      rows = '{
         '{8'h0C, 8'h03, 8'h04, 4'h1, 8'h0C, 8'h00, 8'h00, 8'h00},
         '{8'h1C, 8'h03, 8'h04, 4'h1, 8'h0D, 8'h00, 8'h00, 8'h00},
         '{8'h0E, 8'h03, 8'h04, 4'h1, 8'h1C, 8'h00, 8'h00, 8'h00},
         '{8'h0C, 8'h03, 8'h05, 4'h1, 8'h30, 8'h00, 8'h00, 8'h00},
         '{8'h0C, 8'h00, 8'h04, 4'h1, 8'h00, 8'h00, 8'h00, 8'h00},
         '{8'h0C, 8'hFF, 8'h04, 4'h1, 8'h28, 8'h00, 8'h00, 8'h00},
         '{8'h4C, 8'h03, 8'h04, 4'hF, 8'h28, 8'h00, 8'h00, 8'h0C},
         '{8'hCC, 8'h03, 8'h04, 4'hF, 8'h00, 8'h0C, 8'h28, 8'h00},
         '{8'h4D, 8'h03, 8'h04, 4'hF, 8'h28, 8'h28, 8'h00, 8'h1C},
         '{8'hCF, 8'h03, 8'h04, 4'hF, 8'h28, 8'h1C, 8'h00, 8'h28}};
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      `CHK(poe, 4'h0)
      bus(1'b0, `EBPWM_OFF_CTRL, 32'h0);
      `CHK(v, 32'h0)
      bus(1'b0, 8'h30, 32'h0);
      `CHK(v, 32'h0)
      bus(1'b1, `EBPWM_OFF_PERLIM, 32'h09);
      // Table of output arrangements, polarities and duties
      foreach (rows[i]) begin
         r = rows[i];
         per = r.tc[0] ? 160 : 40;
         bus(1'b1, `EBPWM_OFF_DUTYLO, {24'h0, r.lo});
         bus(1'b1, `EBPWM_OFF_TCTL, {24'h0, r.tc});
         bus(1'b1, `EBPWM_OFF_CTRL, {24'h0, r.ctl});
         repeat (3 * per) @(posedge clk_sys);
         meas(per);
         `CHK(poe, r.oe)
         `CHK(cnt[0], {8'h00, r.a})
         `CHK(cnt[1], {8'h00, r.b})
         `CHK(cnt[2], {8'h00, r.c})
         `CHK(cnt[3], {8'h00, r.d})
         `CHK(cnt[5], 16'h0001)
         bus(1'b0, `EBPWM_OFF_DUTYWK, 32'h0);
         `CHK(v[7:0], r.lo)
      end
      // Working duty is read-only; postscaler leaves the period alone
      bus(1'b1, `EBPWM_OFF_CTRL, 32'h0C);
      bus(1'b1, `EBPWM_OFF_DUTYWK, 32'hAA);
      bus(1'b1, `EBPWM_OFF_TCTL, 32'h1C);
      repeat (200) @(posedge clk_sys);
      meas(160);
      `CHK(cnt[4], 16'h0004)
      `CHK(cnt[5], 16'h0001)
      bus(1'b0, `EBPWM_OFF_DUTYWK, 32'h0);
      `CHK(v[7:0], 8'h03)
      // Half-bridge with dead band, both polarities
      bus(1'b1, `EBPWM_OFF_PERLIM, 32'h13);
      bus(1'b1, `EBPWM_OFF_TCTL, 32'h04);
      bus(1'b1, `EBPWM_OFF_DUTYLO, 32'h0A);
      bus(1'b1, `EBPWM_OFF_DBAND, 32'h02);
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, `EBPWM_OFF_CTRL, m ? 32'h8F : 32'h8C);
         repeat (240) @(posedge clk_sys);
         s0 = shootCnt;
         meas(80);
         lim = m ? 16'h0030 : 16'h001D;
         `CHK(cnt[0] >= lim && cnt[0] <= lim + 3, 1'b1)
         `CHK(cnt[1] >= lim && cnt[1] <= lim + 3, 1'b1)
         `CHK(m ? 16'h0 : shootCnt - s0, 16'h0000)
         `CHK(poe, 4'h3)
      end
      // Dead band longer than either active span
      bus(1'b1, `EBPWM_OFF_DBAND, 32'h7F);
      bus(1'b1, `EBPWM_OFF_CTRL, 32'h8C);
      repeat (240) @(posedge clk_sys);
      meas(80);
      `CHK(cnt[0] + cnt[1], 16'h0000)
      // Unit off returns to reset state
      bus(1'b1, `EBPWM_OFF_CTRL, 32'h00);
      repeat (2) @(posedge clk_sys);
      `CHK(poe, 4'h0)
      bus(1'b0, `EBPWM_OFF_DUTYWK, 32'h0);
      `CHK(v[7:0], 8'h00)
      // Special event clears the selected 16-bit timer only
      bus(1'b1, `EBPWM_OFF_CTRL, 32'h0B);
      bus(1'b1, `EBPWM_OFF_DUTYWK, 32'h00);
      bus(1'b1, `EBPWM_OFF_DUTYLO, 32'h14);
      bus(1'b1, `EBPWM_OFF_CAPCTL, 32'h02);
      repeat (300) @(posedge clk_sys);
      bus(1'b0, `EBPWM_OFF_CAPA, 32'h0);
      `CHK(v[15:0] <= 16'h0014, 1'b1)
      bus(1'b0, `EBPWM_OFF_CAPB, 32'h0);
      `CHK(v[15:0] > 16'h0014, 1'b1)
      // Second timer selected: it alone now wraps at the compare value
      bus(1'b1, `EBPWM_OFF_CAPB, 32'h00);
      bus(1'b1, `EBPWM_OFF_CAPCTL, 32'h03);
      repeat (300) @(posedge clk_sys);
      bus(1'b0, `EBPWM_OFF_CAPB, 32'h0);
      `CHK(v[15:0] <= 16'h0014, 1'b1)
      give_verdict();
   end
endmodule

bind ebpwm_top ebpwm_chk i_chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .bridgeOutA(bridgeOutA), .bridgeOutB(bridgeOutB),
   .bridgeOutC(bridgeOutC), .bridgeOutD(bridgeOutD),
   .bridgeOeA(bridgeOeA), .bridgeOeB(bridgeOeB), .bridgeOeC(bridgeOeC),
   .bridgeOeD(bridgeOeD), .updatePulse(updatePulse));
